// [ieb_enable_bank.sv]
// Interrupt enable bank: APB slave, enable registers and request gating.
// Assumes an APB master on pclk and sources that pulse src_irq high.
//
// The address map and the APB interface to the registers were chosen for this implementation.
`default_nettype none
module ieb_enable_bank
  import ieb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ieb_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ieb_pkg::NUM_SRC-1:0] src_irq,
  output logic [ieb_pkg::NUM_SRC-1:0] irq_req,
  output logic [ieb_pkg::NUM_SRC-1:0][ieb_pkg::PRIO_W-1:0] irq_prio
);
  import ieb_pkg::*;

  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [NUM_SRC-1:0] irq_req_q;
  logic [NUM_SRC-1:0] irq_req_d;
  logic [NUM_REGS-1:0][15:0] enable_q;
  logic [NUM_REGS-1:0][15:0] enable_d;
  logic [NUM_REGS-1:0][15:0] flag_q;
  logic [NUM_REGS-1:0][15:0] impl_w;
  logic [NUM_SRC-1:0][PRIO_W-1:0] prio_q;
  logic [NUM_PRIO_REGS-1:0][15:0] prio_word;
  logic [NUM_SRC-1:0] prio_nz;
  logic [NUM_SRC-1:0] enable_flat;
  logic [NUM_SRC-1:0] flag_flat;
  logic [31:0] rdata_d;
  ieb_wr_s wr;

  assign impl_w = IMPL_MASK;
  assign enable_flat = enable_q;
  assign flag_flat = flag_q;

  // Bus phase decode
  wire setup = psel && !penable;
  wire access = psel && penable && pready_q;
  wire [5:0] widx = paddr[7:2];
  wire aligned = (paddr[ADDR_W-1:8] == '0) && (paddr[1:0] == 2'b00);
  wire hit_en = aligned && (widx <= ENABLE_LAST);
  wire hit_fl = aligned && (widx >= FLAG_IDX) && (widx <= FLAG_LAST);
  wire hit_pr = aligned && (widx >= PRIO_IDX) && (widx <= PRIO_LAST);
  wire hit_any = hit_en || hit_fl || hit_pr;
  wire [2:0] en_sel = 3'(widx - ENABLE_IDX);
  wire [2:0] fl_sel = 3'(widx - FLAG_IDX);
  wire [4:0] pr_sel = 5'(widx - PRIO_IDX);

  // Write strobe shared with the flag and priority banks
  assign wr.en = access && pwrite && hit_any;
  assign wr.idx = widx;
  assign wr.be = pstrb[1:0];
  assign wr.data = pwdata[15:0];

  // Priority fields packed four to a register word
  for (genvar p = 0; p < NUM_PRIO_REGS; p++)
  begin : g_pword
    assign prio_word[p] = {1'b0, prio_q[4*p+3], 1'b0, prio_q[4*p+2],
                           1'b0, prio_q[4*p+1], 1'b0, prio_q[4*p]};
  end

  // Read data select; unmapped addresses read zero
  assign rdata_d = hit_en ? {16'h0000, enable_q[en_sel]} :
                   hit_fl ? {16'h0000, flag_q[fl_sel]} :
                   hit_pr ? {16'h0000, prio_word[pr_sel]} :
                   32'h0000_0000;

  // Enable registers with byte lanes
  for (genvar r = 0; r < NUM_REGS; r++)
  begin : g_enable
    wire hit = wr.en && (widx == ENABLE_IDX + 6'(r));
    wire [15:0] bm = {{8{wr.be[1]}}, {8{wr.be[0]}}};
    wire [15:0] nxt = hit ? ((enable_q[r] & ~bm) | (wr.data & bm))
                          : enable_q[r];
    assign enable_d[r] = nxt & impl_w[r];
  end

  // Per-source request gating
  for (genvar s = 0; s < NUM_SRC; s++)
  begin : g_gate
    assign prio_nz[s] = (prio_q[s] != PRIO_OFF);
    assign irq_req_d[s] = flag_flat[s] && enable_flat[s]
                          && prio_nz[s] && IMPL_MASK[s];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enable_q <= {NUM_REGS{ENABLE_RESET}};
    else
      enable_q <= enable_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_req_q <= '0;
    else
      irq_req_q <= irq_req_d;
  end

  // One-cycle access phase; answer prepared during setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup && !hit_any;
      if (setup)
        prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
    end
  end

  ieb_flag_bank u_flag (
    .pclk(pclk),
    .presetn(presetn),
    .wr(wr),
    .src_set(src_irq),
    .flag_q(flag_q)
  );

  ieb_prio_bank u_prio (
    .pclk(pclk),
    .presetn(presetn),
    .wr(wr),
    .prio_q(prio_q)
  );

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq_req = irq_req_q;
  assign irq_prio = prio_q;

  // Checks
  logic boot_q;
  logic [2:0] sel_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_q <= 1'b1;
      sel_q <= 3'h0;
    end
    else
    begin
      boot_q <= 1'b0;
      sel_q <= en_sel;
    end
  end

  // Completed writes as seen on the bus, per register group
  wire en_wr = psel && penable && pready && pwrite && hit_en;
  wire fl_wr = psel && penable && pready && pwrite && hit_fl;
  wire pr_wr = psel && penable && pready && pwrite && hit_pr;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  sequence s_en_read;
    s_setup and (!pwrite && hit_en);
  endsequence
  sequence s_en_full_write;
    psel && penable && pready && pwrite && hit_en
      && (pstrb[1:0] == 2'b11);
  endsequence

  a_gate_relation: assert property (
    ##1 irq_req == ($past(flag_flat) & $past(enable_flat)
                    & $past(prio_nz) & IMPL_MASK))
    else $error("gated request differs from flag and enable");

  a_gate_blocked: assert property (
    ((irq_req & ~$past(enable_flat)) == '0)
      && ((irq_req & ~$past(flag_flat)) == '0))
    else $error("request passed without enable or flag");

  a_unimpl_zero: assert property (
    (enable_flat & ~IMPL_MASK) == '0)
    else $error("unimplemented enable bit set");

  a_unimpl_read: assert property (
    s_en_read |=> (s_done and ((prdata[15:0] & ~impl_w[sel_q]) == 16'h0)
                   and (prdata[31:16] == 16'h0)))
    else $error("unimplemented enable bit read nonzero");

  a_write_takes: assert property (
    s_en_full_write |=> enable_q[sel_q] ==
      ($past(pwdata[15:0]) & impl_w[sel_q]))
    else $error("enable register write lost");

  a_reset_clear: assert property (
    boot_q |-> (enable_flat == '0) && (irq_req == '0))
    else $error("enables not clear after reset");

  a_prio_off: assert property (
    ##1 (irq_req & ~$past(prio_nz)) == '0)
    else $error("request passed at priority zero");

  a_flag_set: assert property (
    ##1 (flag_flat & $past(src_irq & IMPL_MASK))
        == $past(src_irq & IMPL_MASK))
    else $error("source request did not set its flag");

  a_bus_answer: assert property (
    s_setup |=> s_done ##1 !pready)
    else $error("access phase not answered in one cycle");

  a_bus_error: assert property (
    (s_setup and !hit_any) |=> pslverr && pready)
    else $error("unmapped access not flagged");

  a_err_read_zero: assert property (
    (s_setup and !hit_any) |=> prdata == 32'h0000_0000)
    else $error("unmapped access returned data");

  a_err_ready: assert property (
    pslverr |-> pready)
    else $error("error without ready");

  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("ready held past one cycle");

  a_idle_quiet: assert property (
    !psel |=> !pready && !pslverr)
    else $error("answer without a request");

  a_rd_upper: assert property (
    pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read half nonzero");

  a_en_read_data: assert property (
    s_en_read |=> prdata[15:0] == $past(enable_q[en_sel]))
    else $error("enable read data differs from register");

  a_fl_read_data: assert property (
    (s_setup and (!pwrite && hit_fl)) |=>
      prdata[15:0] == $past(flag_q[fl_sel]))
    else $error("flag read data differs from register");

  a_en_hold: assert property (
    !en_wr |=> enable_flat == $past(enable_flat))
    else $error("enable changed without a write");

  a_lane_keep: assert property (
    en_wr && !pstrb[1] |=>
      enable_q[sel_q][15:8] == $past(enable_q[sel_q][15:8]))
    else $error("upper byte written with its strobe low");

  a_flag_hold: assert property (
    (src_irq == '0) && !fl_wr |=> flag_flat == $past(flag_flat))
    else $error("flag changed without request or write");

  a_prio_hold: assert property (
    !pr_wr |=> irq_prio == $past(irq_prio))
    else $error("priority changed without a write");

  a_req_impl: assert property (
    (irq_req & ~IMPL_MASK) == '0)
    else $error("request on an unimplemented source");

  a_fl_unimpl: assert property (
    (flag_flat & ~IMPL_MASK) == '0)
    else $error("unimplemented flag bit set");

  a_req_latency: assert property (
    ##2 (($past(src_irq & IMPL_MASK, 2) & $past(enable_flat & prio_nz)
          & ~irq_req) == '0))
    else $error("enabled source request not passed in two cycles");

endmodule // ieb_enable_bank
`default_nettype wire

// [ieb_pkg.sv]
// Constants, bit map and write carrier for the interrupt enable bank.
// Assumes a 32-bit APB master and one 250 MHz clock.
`default_nettype none
package ieb_pkg;
  localparam int NUM_REGS = 5;
  localparam int REG_W = 16;
  localparam int NUM_SRC = 80;
  localparam int PRIO_W = 3;
  localparam int NUM_PRIO_REGS = 20;
  localparam int FIELD_STRIDE = 4;
  localparam int ADDR_W = 12;
  // Word indices; byte address is four times the index
  localparam logic [5:0] ENABLE_IDX = 6'h00;
  localparam logic [5:0] ENABLE_LAST = 6'h04;
  localparam logic [5:0] FLAG_IDX = 6'h08;
  localparam logic [5:0] FLAG_LAST = 6'h0c;
  localparam logic [5:0] PRIO_IDX = 6'h10;
  localparam logic [5:0] PRIO_LAST = 6'h23;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] FLAG_RESET = 16'h0000;
  localparam logic [2:0] PRIO_RESET = 3'h4;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  // Source positions, register times sixteen plus bit
  localparam int NONVOLATILE_MEM_EN = 15;
  localparam int CONVERTER_DONE_EN = 13;
  localparam int SERIAL1_TX_EN = 12;
  localparam int SERIAL1_RX_EN = 11;
  localparam int SYNC1_XFER_EN = 10;
  localparam int SYNC1_FAULT_EN = 9;
  localparam int TIMER_THREE_EN = 8;
  localparam int TIMER_TWO_EN = 7;
  localparam int COMPARE_TWO_EN = 6;
  localparam int CAPTURE_TWO_EN = 5;
  localparam int TIMER_ONE_EN = 3;
  localparam int COMPARE_ONE_EN = 2;
  localparam int CAPTURE_ONE_EN = 1;
  localparam int EXT_IRQ_ZERO_EN = 0;
  localparam int SERIAL2_TX_EN = 31;
  localparam int SERIAL2_RX_EN = 30;
  localparam int EXT_IRQ_TWO_EN = 29;
  localparam int TIMER_FIVE_EN = 28;
  localparam int TIMER_FOUR_EN = 27;
  localparam int COMPARE_THREE_EN = 25;
  localparam int EXT_IRQ_ONE_EN = 20;
  localparam int PIN_CHANGE_EN = 19;
  localparam int COMPARATOR_EN = 18;
  localparam int TWOWIRE1_MASTER_EN = 17;
  localparam int TWOWIRE1_SLAVE_EN = 16;
  localparam int CAPTURE_THREE_EN = 37;
  localparam int SYNC2_EVENT_EN = 33;
  localparam int SYNC2_FAULT_EN = 32;
  localparam int CALENDAR_EN = 62;
  localparam int TWOWIRE2_MASTER_EN = 50;
  localparam int TWOWIRE2_SLAVE_EN = 49;
  localparam int CHARGE_TIME_EN = 77;
  localparam int VOLTAGE_DETECT_EN = 72;
  localparam int CHECKSUM_GEN_EN = 67;
  localparam int SERIAL2_ERROR_EN = 66;
  localparam int SERIAL1_ERROR_EN = 65;
  localparam logic [79:0] ONE = 80'h1;
  localparam logic [79:0] IMPL_MASK =
    (ONE << NONVOLATILE_MEM_EN) | (ONE << CONVERTER_DONE_EN) |
    (ONE << SERIAL1_TX_EN) | (ONE << SERIAL1_RX_EN) |
    (ONE << SYNC1_XFER_EN) | (ONE << SYNC1_FAULT_EN) |
    (ONE << TIMER_THREE_EN) | (ONE << TIMER_TWO_EN) |
    (ONE << COMPARE_TWO_EN) | (ONE << CAPTURE_TWO_EN) |
    (ONE << TIMER_ONE_EN) | (ONE << COMPARE_ONE_EN) |
    (ONE << CAPTURE_ONE_EN) | (ONE << EXT_IRQ_ZERO_EN) |
    (ONE << SERIAL2_TX_EN) | (ONE << SERIAL2_RX_EN) |
    (ONE << EXT_IRQ_TWO_EN) | (ONE << TIMER_FIVE_EN) |
    (ONE << TIMER_FOUR_EN) | (ONE << COMPARE_THREE_EN) |
    (ONE << EXT_IRQ_ONE_EN) | (ONE << PIN_CHANGE_EN) |
    (ONE << COMPARATOR_EN) | (ONE << TWOWIRE1_MASTER_EN) |
    (ONE << TWOWIRE1_SLAVE_EN) | (ONE << CAPTURE_THREE_EN) |
    (ONE << SYNC2_EVENT_EN) | (ONE << SYNC2_FAULT_EN) |
    (ONE << CALENDAR_EN) | (ONE << TWOWIRE2_MASTER_EN) |
    (ONE << TWOWIRE2_SLAVE_EN) | (ONE << CHARGE_TIME_EN) |
    (ONE << VOLTAGE_DETECT_EN) | (ONE << CHECKSUM_GEN_EN) |
    (ONE << SERIAL2_ERROR_EN) | (ONE << SERIAL1_ERROR_EN);
  typedef struct packed {
    logic en;
    logic [5:0] idx;
    logic [1:0] be;
    logic [15:0] data;
  } ieb_wr_s;
endpackage
`default_nettype wire

// [ieb_flag_bank.sv]
// Hardware-set, software-cleared flag registers, one bit per source.
// Assumes write requests arrive as one-cycle strobes from the bus slave.
`default_nettype none
module ieb_flag_bank
  import ieb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire ieb_pkg::ieb_wr_s wr,
  input wire logic [ieb_pkg::NUM_SRC-1:0] src_set,
  output logic [ieb_pkg::NUM_REGS-1:0][15:0] flag_q
);
  import ieb_pkg::*;
  logic [NUM_REGS-1:0][15:0] impl_w;
  logic [NUM_REGS-1:0][15:0] flag_d;
  assign impl_w = IMPL_MASK;
  for (genvar r = 0; r < NUM_REGS; r++)
  begin : g_reg
    wire hit = wr.en && (wr.idx == FLAG_IDX + 6'(r));
    wire [15:0] bm = {{8{wr.be[1]}}, {8{wr.be[0]}}};
    wire [15:0] kept = hit ? ((flag_q[r] & ~bm) | (wr.data & bm))
                           : flag_q[r];
    // Set from the source wins over a clear in the same cycle
    assign flag_d[r] = (kept | src_set[r*16 +: 16]) & impl_w[r];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_q <= {NUM_REGS{FLAG_RESET}};
    else
      flag_q <= flag_d;
  end
endmodule // ieb_flag_bank
`default_nettype wire

// [ieb_prio_bank.sv]
// Three-bit priority field per source, four fields to a register.
// Assumes write requests arrive as one-cycle strobes from the bus slave.
`default_nettype none
module ieb_prio_bank
  import ieb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire ieb_pkg::ieb_wr_s wr,
  output logic [ieb_pkg::NUM_SRC-1:0][ieb_pkg::PRIO_W-1:0] prio_q
);
  import ieb_pkg::*;
  logic [NUM_SRC-1:0][PRIO_W-1:0] prio_d;
  for (genvar s = 0; s < NUM_SRC; s++)
  begin : g_src
    localparam int FLD = (s % 4) * FIELD_STRIDE;
    wire hit = wr.en && (wr.idx == PRIO_IDX + 6'(s / 4))
               && wr.be[FLD / 8];
    assign prio_d[s] = hit ? wr.data[FLD +: PRIO_W] : prio_q[s];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prio_q <= {NUM_SRC{PRIO_RESET}};
    else
      prio_q <= prio_d;
  end
endmodule // ieb_prio_bank
`default_nettype wire

// [ieb_src_model.sv]
// Far-side model: peripheral sources raising interrupt requests.
// Assumes the bench names the sources and strobes fire for one cycle.
`default_nettype none
module ieb_src_model
  import ieb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  input wire logic [ieb_pkg::NUM_SRC-1:0] fire_mask,
  output logic [ieb_pkg::NUM_SRC-1:0] src_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // One-cycle request pulse on each named source
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      src_irq <= 80'h0;
    else
      src_irq <= fire ? fire_mask : 80'h0;
  end
endmodule // ieb_src_model
`default_nettype wire

// [ieb_enable_bank_tb.sv]
// Bench for the interrupt enable bank: APB register tests and gating.
// Assumes ieb_pkg, ieb_enable_bank and ieb_src_model compiled first.
`default_nettype none
module ieb_enable_bank_tb;
  import ieb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NUM_SRC-1:0] src_irq;
  logic [NUM_SRC-1:0] irq_req;
  logic [NUM_SRC-1:0][PRIO_W-1:0] irq_prio;
  logic [NUM_SRC-1:0] fire_mask = 80'h0;
  logic fire = 1'b0;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  always #2 pclk = ~pclk;

  ieb_enable_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_irq(src_irq), .irq_req(irq_req), .irq_prio(irq_prio));
  ieb_src_model srcs (.pclk(pclk), .presetn(presetn), .fire(fire),
    .fire_mask(fire_mask), .src_irq(src_irq));

  task automatic close_out;
    $display("Counts: %0d compared, %0d mismatched", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Setup, then access until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      fail_count++;
  endtask

  task automatic pulse(input logic [79:0] m);
    @(posedge pclk);
    fire_mask <= m;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
  endtask

  task automatic settle;
    repeat (4) @(negedge pclk);
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      close_out();
    end
  end

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      apb(1'b0, 12'(4 * i), 32'h0);
      check(80'(rd), 80'h0);
      check(80'(err), 80'h0);
      apb(1'b1, 12'(4 * i), 32'hffffffff);
      apb(1'b0, 12'(4 * i), 32'h0);
      check(80'(rd), 80'(IMPL_MASK[16 * i +: 16]));
      apb(1'b1, 12'(4 * i), 32'h0);
      apb(1'b0, 12'(4 * i), 32'h0);
      check(80'(rd), 80'h0);
    end
    pstrb <= 4'h1;
    apb(1'b1, 12'h000, 32'h0000ffff);
    pstrb <= 4'hf;
    apb(1'b0, 12'h000, 32'h0);
    check(80'(rd), 80'(IMPL_MASK[7:0]));
    apb(1'b0, 12'h014, 32'h0);
    check(80'(err), 80'h1);
    check(80'(rd), 80'h0);
    apb(1'b1, 12'h000, 32'h0);
    $display("Test register maps done");
    pulse({NUM_SRC{1'b1}});
    settle();
    check(irq_req, 80'h0);
    for (int i = 0; i < NUM_REGS; i++)
    begin
      apb(1'b0, 12'(32 + 4 * i), 32'h0);
      check(80'(rd), 80'(IMPL_MASK[16 * i +: 16]));
      apb(1'b1, 12'(4 * i), 32'hffffffff);
    end
    settle();
    check(irq_req, IMPL_MASK);
    apb(1'b1, 12'h040, 32'h0);
    settle();
    check(irq_req, IMPL_MASK & ~80'hf);
    check(80'(irq_prio[0]), 80'(PRIO_OFF));
    check(80'(irq_prio[4]), 80'(PRIO_RESET));
    apb(1'b1, 12'h004, 32'h0);
    settle();
    check(irq_req, IMPL_MASK & ~80'hffff000f);
    for (int i = 0; i < NUM_REGS; i++)
      apb(1'b1, 12'(32 + 4 * i), 32'h0);
    settle();
    check(irq_req, 80'h0);
    pulse(IMPL_MASK);
    settle();
    check(irq_req, IMPL_MASK & ~80'hffff000f);
    $display("Test request gating done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h008, 32'h0);
    check(80'(rd), 80'h0);
    check(80'(irq_prio[0]), 80'(PRIO_RESET));
    $display("Test second reset done");
    close_out();
  end
endmodule // ieb_enable_bank_tb
`default_nettype wire
